// ---- core/tsv_tone_voice_port.v ----
// Functional notes
// - tone sending accepted only in tone, speakerphone or V.21 setup, equalizer zero.
// - 2xh codes use 1375+2002 Hz, 3xh 1529+2225; 20,22,30,32 low level.
// - codes 30h, 32h, 38h, 3Ah still generate their tone pairs.
// - detector runs once enable set and new setup applied in allowed modes.
// - talk-mode tone detectors are unavailable while detector runs in tone mode.
// - valid received signal places its codeword into the receive code register.
// - top bit of receive code register marks a detected dual tone.
// - receive code reads E0h after first segment while single tone still detected.
// - voice coding active only with coder enable, receive voice and allowed setup.
// - sampled, compressed line voice delivered as sixteen-bit words.
// - word rates 900, 1350, 1800 per second for 2, 3, 4 bits.
// - device sets receive-word-full after writing each coded word.
// - interrupt request raised each time word-full sets while enabled.
// - words read through receive byte port, low byte then high byte.
// - low-ready and high-ready flags show which byte may be read.
// - first word of a stream shows aligned and low-ready together.
`timescale 1ns/1ps
`include "tsv_defs.vh"
module tsv_tone_voice_port (
  // clock and reset
  input wire clk,
  input wire srst,
  // register port
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdData,
  // tone generator control
  output reg toneActive,
  output reg toneSegTwo,
  output reg [10:0] toneFreqA,
  output reg [10:0] toneFreqB,
  output reg toneLowLevel,
  output reg terminalReady,
  output reg suppressAnswerTone,
  output reg transmitMute,
  // tone detector results (from analog front end, other domain)
  input wire detDual,
  input wire detSingle,
  input wire detValid,
  input wire [7:0] detCode,
  output reg talkDetEnable,
  // voice coder input sample word (from coder, other domain)
  input wire [15:0] coderWord,
  // interrupt
  output reg irqReq
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SEG1 = 2'd1;
  localparam ST_SEG2 = 2'd2;

  reg [7:0] setup_reg;
  reg [7:0] ctrl_reg;
  reg [1:0] widthSel_reg;
  reg detEnable_reg;
  reg detRun_reg;
  reg [7:0] rxCode_reg;
  reg [1:0] txState_reg;
  reg [7:0] txCode_reg;
  reg [31:0] txCnt_reg;
  reg [31:0] wordCnt_reg;
  reg [15:0] voiceWord_reg;
  reg wordFull_reg;
  reg lowRdy_reg;
  reg highRdy_reg;
  reg aligned_reg;
  reg firstWord_reg;
  wire [10:0] syncDet;
  wire detDualS = syncDet[0];
  wire detSingleS = syncDet[1];
  wire detValidS = syncDet[2];
  wire [7:0] detCodeS = syncDet[10:3];
  wire [15:0] coderWordS;

  // detector results cross as one word so code and valid arrive together
  tsv_sync3 #(.W(11)) uDetSync (
    .clk(clk),
    .srst(srst),
    .asyncIn({detCode, detValid, detSingle, detDual}),
    .syncOut(syncDet)
  );
  tsv_sync3 #(.W(16)) uWordSync (
    .clk(clk),
    .srst(srst),
    .asyncIn(coderWord),
    .syncOut(coderWordS)
  );

  wire toneSetupOk = (setup_reg[7:4] == `TSV_SETUP_TONE_HI) ||
    (setup_reg == `TSV_SETUP_SPKR) ||
    (setup_reg == `TSV_SETUP_V21);
  wire txAllowed = toneSetupOk && !ctrl_reg[`TSV_CTRL_EQSEL];
  wire txEmpty = (txState_reg == ST_IDLE);
  wire coderSetupOk = (setup_reg == `TSV_SETUP_STONE) ||
    (setup_reg == `TSV_SETUP_DTONE) ||
    (setup_reg == `TSV_SETUP_DIAL) ||
    (setup_reg == `TSV_SETUP_DTMF);
  wire coderOn = ctrl_reg[`TSV_CTRL_CODEN] && ctrl_reg[`TSV_CTRL_RXVOICE] &&
    coderSetupOk;
  wire txWrite = regWr && (regAddr == `TSV_ADDR_TXPORT);
  wire rxRead = regRd && (regAddr == `TSV_ADDR_RXPORT);
  // field 0 and the unused code 1 both mean four bits
  wire [31:0] wordPeriod = (widthSel_reg == 2'd2) ? `TSV_WORD2_CYC :
    (widthSel_reg == 2'd3) ? `TSV_WORD3_CYC : `TSV_WORD4_CYC;
  // at or past the period, so a switch to a shorter period cannot strand the count
  wire wordTick = coderOn && (wordCnt_reg >= wordPeriod - 32'd1);
  wire knownCode = (txCode_reg[7:4] == 4'h2) || (txCode_reg[7:4] == 4'h3);
  // 3xh codes use the upper dual pair
  wire segOneHigh = (txCode_reg[7:4] == 4'h3);

  // single tone per codeword
  reg [10:0] segTwoFreq;
  always @*
  begin
    case (txCode_reg)
      8'h20: segTwoFreq = 11'h28A;
      8'h21: segTwoFreq = 11'h47E;
      8'h22: segTwoFreq = 11'h190;
      8'h23: segTwoFreq = 11'h384;
      8'h24: segTwoFreq = 11'h3D4;
      8'h28: segTwoFreq = 11'h28A;
      8'h2A: segTwoFreq = 11'h190;
      8'h30: segTwoFreq = 11'h28A;
      8'h31: segTwoFreq = 11'h47E;
      8'h32: segTwoFreq = 11'h190;
      8'h33: segTwoFreq = 11'h76C;
      8'h34: segTwoFreq = 11'h672;
      8'h38: segTwoFreq = 11'h28A;
      8'h3A: segTwoFreq = 11'h190;
      default: segTwoFreq = 11'h000;
    endcase
  end

  // register writes
  always @(posedge clk)
  begin
    if (srst)
    begin
      setup_reg <= `TSV_RESET_BYTE;
      ctrl_reg <= `TSV_RESET_BYTE;
      widthSel_reg <= 2'd0;
      detEnable_reg <= 1'b0;
      detRun_reg <= 1'b0;
    end
    else
    begin
      if (regWr && regAddr == `TSV_ADDR_SETUP)
        setup_reg <= regWrData;
      if (regWr && regAddr == `TSV_ADDR_CTRL)
      begin
        // the apply bit is a strobe and is never stored
        ctrl_reg <= {regWrData[7:4], 1'b0, regWrData[2:0]};
      end
      if (regWr && regAddr == `TSV_ADDR_TONEDET)
      begin
        detEnable_reg <= regWrData[`TSV_TONEDET_EN];
        if (!regWrData[`TSV_TONEDET_EN])
          detRun_reg <= 1'b0;
        // every code is stored, so four bits can be picked again after two or three
        widthSel_reg <= regWrData[`TSV_TONEDET_WID + 1:`TSV_TONEDET_WID];
      end
      // new setup latches the detector on in any tone (8xh), V.21 or speakerphone setup
      if (regWr && regAddr == `TSV_ADDR_CTRL && regWrData[`TSV_CTRL_APPLY])
        detRun_reg <= detEnable_reg && toneSetupOk;
    end
  end

  // tone transmitter sequencer
  always @(posedge clk)
  begin
    if (srst)
    begin
      txState_reg <= ST_IDLE;
      txCode_reg <= 8'h00;
      txCnt_reg <= 32'd0;
    end
    else
    begin
      case (txState_reg)
        ST_IDLE:
        begin
          txCnt_reg <= 32'd0;
          // writes outside allowed setup are ignored
          // a busy sequencer refuses the write, so the host polls the empty flag
          if (txWrite && txAllowed)
          begin
            txCode_reg <= regWrData;
            txState_reg <= ST_SEG1;
          end
        end
        ST_SEG1:
        begin
          if (txCnt_reg == `TSV_SEG1_CYC - 1)
          begin
            txCnt_reg <= 32'd0;
            txState_reg <= ST_SEG2;
          end
          else
            txCnt_reg <= txCnt_reg + 32'd1;
        end
        ST_SEG2:
        begin
          // mark-tone codes keep their second segment while terminal-ready holds
          if (txCnt_reg >= `TSV_SEG2_CYC - 1 && !(ctrl_reg[`TSV_CTRL_TERMRDY] &&
            (txCode_reg == 8'h24 || txCode_reg == 8'h34)))
            txState_reg <= ST_IDLE;
          else if (txCnt_reg < `TSV_SEG2_CYC - 1)
            txCnt_reg <= txCnt_reg + 32'd1;
        end
        default: txState_reg <= ST_IDLE;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      toneActive <= 1'b0;
      toneSegTwo <= 1'b0;
      toneFreqA <= 11'd0;
      toneFreqB <= 11'd0;
      toneLowLevel <= 1'b0;
      terminalReady <= 1'b0;
      suppressAnswerTone <= 1'b0;
      transmitMute <= 1'b0;
      talkDetEnable <= 1'b0;
    end
    else
    begin
      toneActive <= (txState_reg != ST_IDLE) && knownCode;
      toneSegTwo <= (txState_reg == ST_SEG2) && knownCode;
      // undefined 30h/32h/38h/3Ah codes still get their pairs
      toneFreqA <= segOneHigh ? 11'h5F9 : 11'h55F;
      toneFreqB <= (txState_reg == ST_SEG2) ? segTwoFreq :
        segOneHigh ? 11'h8B1 : 11'h7D2;
      toneLowLevel <= (txCode_reg[3:0] == 4'h0 || txCode_reg[3:0] == 4'h2);
      terminalReady <= ctrl_reg[`TSV_CTRL_TERMRDY];
      suppressAnswerTone <= ctrl_reg[`TSV_CTRL_NOANS];
      transmitMute <= ctrl_reg[`TSV_CTRL_MUTE];
      talkDetEnable <= !(detRun_reg && setup_reg[7:4] == `TSV_SETUP_TONE_HI);
    end
  end

  // tone receive code register
  // the last result stays until the detector reports again
  always @(posedge clk)
  begin
    if (srst)
      rxCode_reg <= 8'h00;
    else if (detRun_reg)
    begin
      if (detValidS)
        rxCode_reg <= {detDualS, detCodeS[6:0]};
      else if (detDualS && detSingleS)
        rxCode_reg <= `TSV_RXCODE_SEG1;
    end
  end

  // voice word path
  // an unread word is simply overwritten; a slow host loses samples
  always @(posedge clk)
  begin
    if (srst)
    begin
      wordCnt_reg <= 32'd0;
      voiceWord_reg <= 16'h0000;
      wordFull_reg <= 1'b0;
      lowRdy_reg <= 1'b0;
      highRdy_reg <= 1'b0;
      aligned_reg <= 1'b0;
      firstWord_reg <= 1'b1;
      irqReq <= 1'b0;
    end
    else
    begin
      irqReq <= 1'b0;
      if (!coderOn)
      begin
        wordCnt_reg <= 32'd0;
        firstWord_reg <= 1'b1;
        aligned_reg <= 1'b0;
      end
      else if (wordTick)
        wordCnt_reg <= 32'd0;
      else
        wordCnt_reg <= wordCnt_reg + 32'd1;
      // byte reads: low then high; the new word wins over a same-cycle read
      if (rxRead && lowRdy_reg)
      begin
        lowRdy_reg <= 1'b0;
        highRdy_reg <= 1'b1;
        aligned_reg <= 1'b0;
      end
      else if (rxRead && highRdy_reg)
      begin
        highRdy_reg <= 1'b0;
        wordFull_reg <= 1'b0;
      end
      if (wordTick)
      begin
        voiceWord_reg <= coderWordS;
        wordFull_reg <= 1'b1;
        lowRdy_reg <= 1'b1;
        highRdy_reg <= 1'b0;
        aligned_reg <= firstWord_reg;
        firstWord_reg <= 1'b0;
        irqReq <= ctrl_reg[`TSV_CTRL_IRQEN];
      end
    end
  end

  // status byte, polled by the host ahead of every data read
  wire [7:0] statusByte = {1'b0, talkDetEnable, detRun_reg, aligned_reg,
    highRdy_reg, lowRdy_reg, wordFull_reg, txEmpty};
  // read port, one cycle latency
  // idle cycles read as zero so a late sample of the bus shows up
  always @(posedge clk)
  begin
    if (srst)
      regRdData <= 8'h00;
    else if (regRd)
    begin
      case (regAddr)
        `TSV_ADDR_RXCODE: regRdData <= rxCode_reg;
        `TSV_ADDR_SETUP: regRdData <= setup_reg;
        `TSV_ADDR_CTRL: regRdData <= ctrl_reg;
        `TSV_ADDR_TONEDET: regRdData <= {4'h0, widthSel_reg, 1'b0, detEnable_reg};
        `TSV_ADDR_STATUS: regRdData <= statusByte;
        `TSV_ADDR_RXPORT: regRdData <= lowRdy_reg ? voiceWord_reg[7:0] :
          voiceWord_reg[15:8];
        default: regRdData <= 8'h00;
      endcase
    end
    else
      regRdData <= 8'h00;
  end
endmodule // tsv_tone_voice_port

// ---- core/tsv_defs.vh ----
`ifndef TSV_DEFS_VH
`define TSV_DEFS_VH
// register offsets (byte-wide interface memory)
`define TSV_ADDR_RXCODE 8'h16
`define TSV_ADDR_TXPORT 8'h10
`define TSV_ADDR_RXPORT 8'h00
`define TSV_ADDR_SETUP 8'h12
`define TSV_ADDR_CTRL 8'h13
`define TSV_ADDR_STATUS 8'h1E
`define TSV_ADDR_TONEDET 8'h39
// control bit positions
`define TSV_CTRL_CODEN 0
`define TSV_CTRL_RXVOICE 1
`define TSV_CTRL_IRQEN 2
`define TSV_CTRL_APPLY 3
`define TSV_CTRL_EQSEL 4
`define TSV_CTRL_MUTE 5
`define TSV_CTRL_TERMRDY 6
`define TSV_CTRL_NOANS 7
// status bit positions
`define TSV_ST_TXEMPTY 0
`define TSV_ST_WORDFULL 1
`define TSV_ST_LOWRDY 2
`define TSV_ST_HIGHRDY 3
`define TSV_ST_ALIGNED 4
`define TSV_ST_DETRUN 5
`define TSV_ST_TALKDET 6
// detector control bit positions
`define TSV_TONEDET_EN 0
`define TSV_TONEDET_WID 2
// setup codes
`define TSV_SETUP_TONE_HI 4'h8
`define TSV_SETUP_V21 8'hA0
`define TSV_SETUP_SPKR 8'hAC
`define TSV_SETUP_STONE 8'h80
`define TSV_SETUP_DTONE 8'h83
`define TSV_SETUP_DIAL 8'h81
`define TSV_SETUP_DTMF 8'h86
`define TSV_RXCODE_SEG1 8'hE0
// timing
`define TSV_CLK_HZ 100000000
`define TSV_SEG1_US 100
`define TSV_SEG2_US 100
`define TSV_SEG1_CYC ((`TSV_SEG1_US * (`TSV_CLK_HZ / 1000000)))
`define TSV_SEG2_CYC ((`TSV_SEG2_US * (`TSV_CLK_HZ / 1000000)))
// 2/3/4 bits per sample at 7200 Hz gives 900/1350/1800 words per second
`define TSV_WORD2_CYC (`TSV_CLK_HZ / 900)
`define TSV_WORD3_CYC (`TSV_CLK_HZ / 1350)
`define TSV_WORD4_CYC (`TSV_CLK_HZ / 1800)
`define TSV_RESET_BYTE 8'h00
`endif

// ---- core/tsv_sync3.v ----
`timescale 1ns/1ps
module tsv_sync3 #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // asynchronous in, filtered out
  input wire [W-1:0] asyncIn,
  output reg [W-1:0] syncOut
);
  reg [W-1:0] stage1_reg;
  reg [W-1:0] stage2_reg;
  reg [W-1:0] stage3_reg;
  always @(posedge clk)
  begin
    if (srst)
    begin
      stage1_reg <= {W{1'b0}};
      stage2_reg <= {W{1'b0}};
      stage3_reg <= {W{1'b0}};
      syncOut <= {W{1'b0}};
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      // a change counts only once the last two stages agree
      if (stage2_reg == stage3_reg)
        syncOut <= stage3_reg;
    end
  end
endmodule // tsv_sync3

// ---- tb/tsv_port_asserts.sv ----
`timescale 1ns/1ps
`include "tsv_defs.vh"
module tsv_port_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // tone, control and interrupt outputs
  input wire logic toneActive,
  input wire logic toneSegTwo,
  input wire logic [10:0] toneFreqA,
  input wire logic [10:0] toneFreqB,
  input wire logic toneLowLevel,
  input wire logic terminalReady,
  input wire logic transmitMute,
  input wire logic irqReq
);
  logic irqEn_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence sCtrlWr;
    regWr && regAddr == `TSV_ADDR_CTRL;
  endsequence
  sequence sSegOne;
    toneActive && !toneSegTwo;
  endsequence
  // last written enable, so an irq is never blamed on a stale setting
  always_ff @(posedge clk)
  begin
    if (srst)
      irqEn_reg <= 1'b0;
    else if (regWr && regAddr == `TSV_ADDR_CTRL)
      irqEn_reg <= regWrData[`TSV_CTRL_IRQEN];
  end
  AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 8'h00)
    else $error("read data not zero outside its answer cycle");
  AST_SEG1_PAIR: assert property (sSegOne |-> (toneFreqA == 11'h55F && toneFreqB == 11'h7D2)
    || (toneFreqA == 11'h5F9 && toneFreqB == 11'h8B1))
    else $error("first segment pair wrong");
  AST_SEG_START: assert property ($rose(toneActive) |-> sSegOne [*8])
    else $error("send did not open with the dual tone");
  AST_SEG2_SET: assert property (toneActive && toneSegTwo |-> toneFreqB inside
    {11'h28A, 11'h47E, 11'h190, 11'h384, 11'h3D4, 11'h76C, 11'h672})
    else $error("second segment tone wrong");
  AST_SEG2_IN_SEND: assert property (toneSegTwo |-> toneActive)
    else $error("single tone outside a send");
  AST_LOW_LEVEL: assert property (toneLowLevel && toneSegTwo |->
    toneFreqB == 11'h28A || toneFreqB == 11'h190)
    else $error("low level on a full level code");
  AST_MUTE_FOLLOW: assert property (sCtrlWr |->
    ##2 transmitMute == $past(regWrData[`TSV_CTRL_MUTE], 2))
    else $error("mute output does not follow control");
  AST_TERM_FOLLOW: assert property (sCtrlWr |->
    ##2 terminalReady == $past(regWrData[`TSV_CTRL_TERMRDY], 2))
    else $error("terminal ready does not follow control");
  AST_IRQ_PULSE: assert property (irqReq |-> irqEn_reg ##1 !irqReq)
    else $error("irq not a single enabled pulse");
endmodule // tsv_port_asserts

bind tsv_tone_voice_port tsv_port_asserts tsv_port_asserts_inst (.clk(clk), .srst(srst),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .toneActive(toneActive), .toneSegTwo(toneSegTwo),
  .toneFreqA(toneFreqA), .toneFreqB(toneFreqB), .toneLowLevel(toneLowLevel),
  .terminalReady(terminalReady), .transmitMute(transmitMute), .irqReq(irqReq));

// ---- tb/tsv_host_model.sv ----
`timescale 1ns/1ps
`include "tsv_defs.vh"
module tsv_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [7:0] regRdData
);
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask
  task automatic sendCode(input logic [7:0] c);
    logic [7:0] s;
    s = 8'h00;
    while (s[`TSV_ST_TXEMPTY] !== 1'b1)
      rd(`TSV_ADDR_STATUS, s);
    wr(`TSV_ADDR_TXPORT, c);
  endtask
  task automatic rdPort(output logic [7:0] st, output logic [7:0] d);
    rd(`TSV_ADDR_STATUS, st);
    rd(`TSV_ADDR_RXPORT, d);
  endtask
endmodule // tsv_host_model

// ---- tb/tsv_tb.sv ----
`timescale 1ns/1ps
`include "tsv_defs.vh"
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic detDual = 1'b0;
  logic detSingle = 1'b0;
  logic detValid = 1'b0;
  logic [7:0] detCode = 8'h00;
  logic [15:0] coderWord = 16'hA5C3;
  logic [7:0] regAddr, regWrData, regRdData, s, d;
  logic regWr, regRd, toneActive, toneSegTwo, toneLowLevel, talkDetEnable, irqReq;
  logic terminalReady, suppressAnswerTone, transmitMute;
  logic [10:0] toneFreqA, toneFreqB;
  int n_checks = 0;
  int miscompares = 0;
  int i;
  always #5 clk = ~clk;
  tsv_host_model tsv_host_model_inst (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  tsv_tone_voice_port tsv_tone_voice_port_inst (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .toneActive(toneActive), .toneSegTwo(toneSegTwo), .toneFreqA(toneFreqA),
    .toneFreqB(toneFreqB), .toneLowLevel(toneLowLevel), .terminalReady(terminalReady),
    .suppressAnswerTone(suppressAnswerTone), .transmitMute(transmitMute),
    .detDual(detDual), .detSingle(detSingle),
    .detValid(detValid), .detCode(detCode), .talkDetEnable(talkDetEnable),
    .coderWord(coderWord), .irqReq(irqReq));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // waits sample 1 ns after the edge so the design's updates have landed
  task automatic waitSeg(input logic two, input int n);
    i = 0;
    do
    begin
      @(posedge clk);
      #1;
      i++;
    end
    while (toneSegTwo !== two && i < n);
  endtask
  task automatic test_detect();
    tsv_host_model_inst.wr(`TSV_ADDR_TONEDET, 8'h01);
    tsv_host_model_inst.wr(`TSV_ADDR_SETUP, `TSV_SETUP_DIAL);
    tsv_host_model_inst.wr(`TSV_ADDR_CTRL, 8'h08);
    repeat (3) @(posedge clk);
    tsv_host_model_inst.rd(`TSV_ADDR_STATUS, s);
    chk("detector running", 1, s[`TSV_ST_DETRUN]);
    chk("talk detectors", 0, talkDetEnable);
    @(posedge clk);
    detDual <= 1'b1;
    detSingle <= 1'b1;
    repeat (8) @(posedge clk);
    tsv_host_model_inst.rd(`TSV_ADDR_RXCODE, s);
    chk("segment one code", `TSV_RXCODE_SEG1, s);
    @(posedge clk);
    detCode <= 8'h23;
    detValid <= 1'b1;
    repeat (8) @(posedge clk);
    tsv_host_model_inst.rd(`TSV_ADDR_RXCODE, s);
    chk("received code", 8'hA3, s);
    @(posedge clk);
    detValid <= 1'b0;
    detDual <= 1'b0;
    detSingle <= 1'b0;
  endtask
  task automatic test_refused();
    tsv_host_model_inst.wr(`TSV_ADDR_SETUP, 8'h10);
    tsv_host_model_inst.wr(`TSV_ADDR_TXPORT, 8'h24);
    repeat (4) @(posedge clk);
    #1;
    chk("send in data setup", 0, toneActive);
    tsv_host_model_inst.wr(`TSV_ADDR_SETUP, `TSV_SETUP_V21);
    tsv_host_model_inst.wr(`TSV_ADDR_CTRL, 8'h10);
    tsv_host_model_inst.wr(`TSV_ADDR_TXPORT, 8'h24);
    repeat (4) @(posedge clk);
    #1;
    chk("send with equalizer", 0, toneActive);
    tsv_host_model_inst.wr(`TSV_ADDR_CTRL, 8'h00);
  endtask
  task automatic test_mark();
    tsv_host_model_inst.sendCode(8'h34);
    tsv_host_model_inst.wr(`TSV_ADDR_CTRL, 8'hC0);
    #1;
    chk("pair low", 11'h5F9, toneFreqA);
    chk("pair high", 11'h8B1, toneFreqB);
    chk("full level", 0, toneLowLevel);
    waitSeg(1'b1, `TSV_SEG1_CYC + 100);
    chk("mark tone", 11'h672, toneFreqB);
    chk("terminal ready", 1, terminalReady);
    chk("answer tone off", 1, suppressAnswerTone);
    // terminal ready keeps the mark tone past its nominal length
    repeat (`TSV_SEG2_CYC + 100) @(posedge clk);
    #1;
    chk("mark held", 1, toneActive);
    tsv_host_model_inst.wr(`TSV_ADDR_CTRL, 8'h00);
    i = 0;
    do
    begin
      @(posedge clk);
      #1;
      i++;
    end
    while (toneActive !== 1'b0 && i < 10);
    chk("send ended", 0, toneActive);
  endtask
  task automatic test_undefined();
    tsv_host_model_inst.wr(`TSV_ADDR_SETUP, `TSV_SETUP_STONE);
    tsv_host_model_inst.sendCode(8'h30);
    tsv_host_model_inst.rd(`TSV_ADDR_STATUS, s);
    chk("port busy", 0, s[`TSV_ST_TXEMPTY]);
    chk("low level", 1, toneLowLevel);
    chk("pair low", 11'h5F9, toneFreqA);
    waitSeg(1'b1, `TSV_SEG1_CYC + 100);
    chk("single tone", 11'h28A, toneFreqB);
  endtask
  task automatic test_voice();
    tsv_host_model_inst.wr(`TSV_ADDR_TONEDET, 8'h0C);
    tsv_host_model_inst.rd(`TSV_ADDR_TONEDET, s);
    chk("three bit width", 8'h0C, s);
    tsv_host_model_inst.wr(`TSV_ADDR_TONEDET, 8'h00);
    tsv_host_model_inst.rd(`TSV_ADDR_TONEDET, s);
    chk("four bit width", 8'h00, s);
    tsv_host_model_inst.wr(`TSV_ADDR_CTRL, 8'h27);
    i = 0;
    do
    begin
      @(posedge clk);
      #1;
      i++;
    end
    while (irqReq !== 1'b1 && i < `TSV_WORD4_CYC + 200);
    chk("word irq", 1, irqReq);
    chk("transmit mute", 1, transmitMute);
    chk("word period", 1, i >= `TSV_WORD4_CYC - 20 && i <= `TSV_WORD4_CYC + 20);
    tsv_host_model_inst.rdPort(s, d);
    chk("first status", 8'h16, s & 8'h1E);
    chk("low byte", 8'hC3, d);
    tsv_host_model_inst.rdPort(s, d);
    chk("second status", 8'h08, s & 8'h0C);
    chk("high byte", 8'hA5, d);
    tsv_host_model_inst.rd(`TSV_ADDR_STATUS, s);
    chk("word drained", 0, s[`TSV_ST_WORDFULL]);
    tsv_host_model_inst.rd(8'h55, s);
    chk("unmapped read", 8'h00, s);
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    test_detect();
    test_refused();
    test_mark();
    test_undefined();
    test_voice();
    finish_test();
  end
endmodule // tb
